// >>> design/irq_mask_pkg.sv
// Package for the interrupt enable mask block: register map, bit layout, reset values.
// Assumes a plain address/strobe register port clocked by the core clock.
package irq_mask_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int SRC_N = 8;
    // Register offsets
    localparam logic [3:0] MASK_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h1;
    localparam logic [3:0] PENDING_OFFSET = 4'h2;
    // Mask bit positions
    localparam int TIMER_OVERFLOW_BIT = 0;
    localparam int INPUT_CHANGE_BIT = 1;
    localparam int EXTERNAL_PIN_BIT = 2;
    localparam int CONVERSION_BIT = 3;
    localparam int PULSE_CH1_BIT = 4;
    localparam int PULSE_CH2_BIT = 5;
    localparam int PULSE_CH3_BIT = 6;
    localparam int COMPARATOR_BIT = 7;
    // Status register bit positions
    localparam int STATUS_GLOBAL_BIT = 0;
    localparam int STATUS_REQUEST_BIT = 1;
    localparam int STATUS_WAKE_BIT = 2;
    // Reset values
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // Global enable state
    typedef enum logic [0:0] {
        GLOBAL_OFF = 1'b0,
        GLOBAL_ON = 1'b1
    } global_state_type;
endpackage

// >>> design/mask_gate.sv
// Gates each source flag by its mask bit, and by the global enable on vector_out only.
// Assumes flags arrive on the core clock; purely combinational.
`timescale 1ns/1ps
module mask_gate #(
    parameter int SRC_N = 8
) (
    input wire logic [SRC_N-1:0] flag_in, // Raw source flags
    input wire logic [SRC_N-1:0] mask_in, // Per-source enable bits
    input wire logic global_in, // Global enable
    output logic [SRC_N-1:0] wake_out, // Flags passed by mask only
    output logic [SRC_N-1:0] vector_out // Flags passed by mask and global enable
);
    // Per-bit gating; wake ignores the global enable so sleep can resume at the next instruction
    genvar i;
    generate
        for (i = 0; i < SRC_N; i++)
        begin : g_bit
            assign wake_out[i] = flag_in[i] & mask_in[i];
            assign vector_out[i] = flag_in[i] & mask_in[i] & global_in;
        end
    endgenerate
endmodule // mask_gate

// >>> design/global_enable.sv
// Global interrupt enable flip-flop, set and cleared by instruction strobes.
// Assumes one-cycle strobes from the instruction decoder on the core clock.
`timescale 1ns/1ps
module global_enable
    import irq_mask_pkg::*;
(
    input wire logic ref_clk_in, // Core clock
    input wire logic reset_in, // Synchronous reset, active high
    input wire logic enable_interrupts_instr_in, // Enable-interrupts strobe
    input wire logic disable_interrupts_instr_in, // Disable-interrupts strobe
    output logic global_out // Global enable level
);
    global_state_type state_q;
    global_state_type state_d;

    // Disable wins if both strobes coincide, the safer outcome
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            GLOBAL_OFF:
            begin
                if (enable_interrupts_instr_in && !disable_interrupts_instr_in)
                    state_d = GLOBAL_ON; // (R3)
            end
            GLOBAL_ON:
            begin
                if (disable_interrupts_instr_in)
                    state_d = GLOBAL_OFF; // (R3)
            end
            default:
                state_d = GLOBAL_OFF;
        endcase
    end

    // Register the state
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            state_q <= GLOBAL_OFF;
        else
            state_q <= state_d;
    end

    assign global_out = (state_q == GLOBAL_ON);
endmodule // global_enable

// >>> design/interrupt_enable_mask.sv
// Interrupt enable mask: eight per-source enables, a global enable, and the gated request.
// Assumes flags and instruction strobes come from core logic on ref_clk_in; no synchroniser needed.
// How it works
// (R1) Mask register is read/write; reads return the last written byte in full.
// (R2) A source is enabled when its mask bit is 1, masked at 0.
// (R3) Global enable set by enable instruction, cleared by disable, separate from mask.
// (R4) Bit 7 gates the comparator change flag.
// (R5) Software sets comparator enable before relying on comparator interrupts or wake.
// (R6) Bit 6 gates pulse channel 3 flag.
// (R7) Bit 5 gates pulse channel 2 flag.
// (R8) Bit 4 gates pulse channel 1 flag.
// (R9) Bit 3 gates the converter-complete flag.
// (R10) Software sets converter enable before relying on its interrupt or wake.
// (R11) Bit 2 gates the external pin flag.
// (R12) Bit 1 gates the port input-change flag.
// (R13) Software sets input-change enable before relying on its interrupt or wake.
// (R14) Bit 0 gates the timer overflow flag.
// (R15) Vector request only with flag set, mask bit 1 and global enable set.
// (R16) All mask bits clear on reset.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
module interrupt_enable_mask
    import irq_mask_pkg::*;
(
    input wire logic ref_clk_in, // Core clock, 20 MHz
    input wire logic reset_in, // Synchronous reset, active high
    input wire logic [irq_mask_pkg::ADDR_W-1:0] reg_addr_in, // Register address
    input wire logic [irq_mask_pkg::DATA_W-1:0] reg_wdata_in, // Write data
    input wire logic reg_write_in, // Write strobe
    input wire logic reg_read_in, // Read strobe
    output logic [irq_mask_pkg::DATA_W-1:0] reg_rdata_out, // Read data, cycle after strobe
    input wire logic enable_interrupts_instr_in, // Enable-interrupts instruction strobe
    input wire logic disable_interrupts_instr_in, // Disable-interrupts instruction strobe
    input wire logic comparator_change_flag_in, // Comparator change flag
    input wire logic pulse_ch3_flag_in, // Pulse channel 3 flag
    input wire logic pulse_ch2_flag_in, // Pulse channel 2 flag
    input wire logic pulse_ch1_flag_in, // Pulse channel 1 flag
    input wire logic conversion_done_flag_in, // Converter complete flag
    input wire logic external_pin_flag_in, // External pin flag
    input wire logic input_change_flag_in, // Port input-change flag
    input wire logic timer_overflow_flag_in, // Timer overflow flag
    output logic [irq_mask_pkg::SRC_N-1:0] pending_out, // Enabled and pending sources
    output logic vector_request_out, // Request jump to the interrupt vector
    output logic wake_request_out, // Release core from sleep
    output logic global_enable_out // Global enable level
);
    logic [DATA_W-1:0] mask_q;
    logic [DATA_W-1:0] mask_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [SRC_N-1:0] flags;
    logic [SRC_N-1:0] wake_bits;
    logic [SRC_N-1:0] vector_bits;
    logic global_en;

    // Address match, used by both the write and the read path
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offs);
        hit = (addr == offs);
    endfunction

    // Collect the flags into mask bit order
    always_comb
    begin
        flags = '0;
        flags[COMPARATOR_BIT] = comparator_change_flag_in; // (R4)
        flags[PULSE_CH3_BIT] = pulse_ch3_flag_in; // (R6)
        flags[PULSE_CH2_BIT] = pulse_ch2_flag_in; // (R7)
        flags[PULSE_CH1_BIT] = pulse_ch1_flag_in; // (R8)
        flags[CONVERSION_BIT] = conversion_done_flag_in; // (R9)
        flags[EXTERNAL_PIN_BIT] = external_pin_flag_in; // (R11)
        flags[INPUT_CHANGE_BIT] = input_change_flag_in; // (R12)
        flags[TIMER_OVERFLOW_BIT] = timer_overflow_flag_in; // (R14)
    end

    global_enable u_global (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .enable_interrupts_instr_in(enable_interrupts_instr_in),
        .disable_interrupts_instr_in(disable_interrupts_instr_in),
        .global_out(global_en)
    );

    mask_gate #(
        .SRC_N(SRC_N)
    ) u_gate (
        .flag_in(flags),
        .mask_in(mask_q), // (R2)
        .global_in(global_en),
        .wake_out(wake_bits),
        .vector_out(vector_bits)
    );

    // Mask write; all eight bits stored so a read returns them unchanged
    always_comb
    begin
        mask_d = mask_q;
        if (reg_write_in && hit(reg_addr_in, MASK_OFFSET))
            mask_d = reg_wdata_in; // (R1)
    end

    // Read mux; unmapped addresses read as zero. Status reflects the global enable and requests
    always_comb
    begin
        rdata_d = ZERO_BYTE;
        if (reg_read_in)
        begin
            if (hit(reg_addr_in, MASK_OFFSET))
                rdata_d = mask_q; // (R1)
            else if (hit(reg_addr_in, STATUS_OFFSET))
            begin
                rdata_d[STATUS_GLOBAL_BIT] = global_en;
                rdata_d[STATUS_REQUEST_BIT] = |vector_bits;
                rdata_d[STATUS_WAKE_BIT] = |wake_bits;
            end
            else if (hit(reg_addr_in, PENDING_OFFSET))
                rdata_d = wake_bits;
        end
    end

    // Registers; read data holds only the cycle after the strobe
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            mask_q <= MASK_RESET; // (R16)
            rdata_q <= ZERO_BYTE;
        end
        else
        begin
            mask_q <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    // Request outputs are combinational so a flag reaches the core in its own cycle
    assign reg_rdata_out = rdata_q;
    assign pending_out = wake_bits;
    assign vector_request_out = |vector_bits; // (R15)
    assign wake_request_out = |wake_bits; // (R2)
    assign global_enable_out = global_en;
endmodule // interrupt_enable_mask

// >>> test/irq_mask_monitor.sv
// Checker for the interrupt enable mask block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module irq_mask_monitor
    import irq_mask_pkg::*;
(
    input wire logic ref_clk_in, // Core clock
    input wire logic reset_in, // Sync reset
    input wire logic [irq_mask_pkg::ADDR_W-1:0] reg_addr_in, // Address
    input wire logic [irq_mask_pkg::DATA_W-1:0] reg_wdata_in, // Write data
    input wire logic reg_write_in, // Write strobe
    input wire logic reg_read_in, // Read strobe
    input wire logic [irq_mask_pkg::DATA_W-1:0] reg_rdata_out, // Read data
    input wire logic enable_interrupts_instr_in, // Enable strobe
    input wire logic disable_interrupts_instr_in, // Disable strobe
    input wire logic [irq_mask_pkg::SRC_N-1:0] pending_out, // Gated flags
    input wire logic vector_request_out, // Vector request
    input wire logic wake_request_out, // Wake request
    input wire logic global_enable_out // Global enable
);
    // One clock domain, so one default clocking and reset
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    sequence mask_write_s; reg_write_in && reg_addr_in == MASK_OFFSET; endsequence
    sequence mask_read_s; reg_read_in && reg_addr_in == MASK_OFFSET; endsequence
    readback_value_a: assert property (mask_write_s ##1 mask_read_s |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("mask readback differs from write");
    rdata_idle_a: assert property (!reg_read_in |=> reg_rdata_out == ZERO_BYTE)
        else $error("read data not zero when idle");
    global_set_a: assert property (enable_interrupts_instr_in && !disable_interrupts_instr_in |=> global_enable_out)
        else $error("global enable not set");
    global_clear_a: assert property (disable_interrupts_instr_in |=> !global_enable_out)
        else $error("global enable not cleared");
    global_hold_a: assert property (!enable_interrupts_instr_in && !disable_interrupts_instr_in |=> $stable(global_enable_out))
        else $error("global enable moved alone");
    vector_gate_a: assert property (vector_request_out == (|pending_out && global_enable_out))
        else $error("vector request wrong");
    wake_gate_a: assert property (wake_request_out == |pending_out)
        else $error("wake request wrong");
    mask_block_a: assert property (mask_write_s |=> (pending_out & ~$past(reg_wdata_in)) == ZERO_BYTE)
        else $error("masked source passed");
    reset_clear_a: assert property ($past(reset_in) |-> pending_out == ZERO_BYTE && !global_enable_out)
        else $error("state not clear after reset");
endmodule // irq_mask_monitor
bind interrupt_enable_mask irq_mask_monitor u_irq_mask_monitor (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .enable_interrupts_instr_in(enable_interrupts_instr_in),
    .disable_interrupts_instr_in(disable_interrupts_instr_in), .pending_out(pending_out),
    .vector_request_out(vector_request_out), .wake_request_out(wake_request_out), .global_enable_out(global_enable_out));

// >>> test/interrupt_enable_mask_test.sv
// Testbench for the interrupt enable mask block.
// Assumes the bound checker; results are read back over the register port and from the request outputs.
`timescale 1ns/1ps
module test_interrupt_enable_mask;
    import irq_mask_pkg::*;
    logic clk = 0, rst = 1, we = 0, re = 0, en = 0, dis = 0, rd_q = 0;
    logic [3:0] addr = '0;
    logic [7:0] wd = '0, flg = '0, f, rdata, exp_q[$];
    logic [7:0] pend;
    logic vreq, wreq, gen;
    logic [3:0] exp_a_q[$];
    logic [7:0] e_now;
    logic [3:0] a_now;
    int n_errors = 0, comparisons = 0;
    always #25 clk = ~clk;
    interrupt_enable_mask u_interrupt_enable_mask (.ref_clk_in(clk), .reset_in(rst), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_write_in(we), .reg_read_in(re), .reg_rdata_out(rdata),
        .enable_interrupts_instr_in(en), .disable_interrupts_instr_in(dis), .comparator_change_flag_in(flg[7]),
        .pulse_ch3_flag_in(flg[6]), .pulse_ch2_flag_in(flg[5]), .pulse_ch1_flag_in(flg[4]),
        .conversion_done_flag_in(flg[3]), .external_pin_flag_in(flg[2]), .input_change_flag_in(flg[1]),
        .timer_overflow_flag_in(flg[0]), .pending_out(pend), .vector_request_out(vreq), .wake_request_out(wreq),
        .global_enable_out(gen));
    task results;
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task check(input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e)
        begin
            $display("wrong value rdata expected %h seen %h", e, s);
            n_errors++;
        end
    endtask
    // Direct outputs; they follow mask and global, which hold still in the cycle the read data stand
    task check_out(input string name, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e)
        begin
            $display("wrong value %s expected %h seen %h", name, e, s);
            n_errors++;
        end
    endtask
    // One bus cycle; a read notes its expected byte, strobes never overlap
    task op(input logic w, input logic [3:0] a, input logic [7:0] d);
        we <= w;
        re <= !w;
        en <= 0;
        dis <= 0;
        addr <= a;
        wd <= d;
        if (!w)
        begin
            exp_q.push_back(d);
            exp_a_q.push_back(a);
        end
        @(posedge clk);
    endtask
    task ins(input logic e, input logic d);
        we <= 0;
        re <= 0;
        en <= e;
        dis <= d;
        @(posedge clk);
    endtask
    // Read data stand only in the cycle after the strobe, so look mid-cycle
    always @(posedge clk) rd_q <= re;
    always @(negedge clk)
    begin
        if (rd_q)
        begin
            e_now = exp_q.pop_front();
            a_now = exp_a_q.pop_front();
            check(e_now, rdata);
            if (a_now == PENDING_OFFSET)
                check_out("pending_out", e_now, pend);
            if (a_now == STATUS_OFFSET)
                check_out("request outputs", e_now, {5'h00, wreq, vreq, gen});
        end
    end
    // Watchdog, far beyond the roughly 60 cycles the run needs
    initial
    begin
        repeat (2000) @(posedge clk);
        n_errors++;
        results;
    end
    initial
    begin
        void'($urandom(96750));
        repeat (16) @(posedge clk);
        rst <= 0;
        op(0, MASK_OFFSET, MASK_RESET);
        for (int i = 0; i < SRC_N; i++)
        begin
            f = 8'($urandom) | (8'h01 << i);
            flg <= f;
            op(1, MASK_OFFSET, 8'h01 << i);
            op(0, PENDING_OFFSET, 8'h01 << i);
            op(0, MASK_OFFSET, 8'h01 << i);
        end
        // Writes elsewhere are ignored and unmapped reads give zero
        op(1, STATUS_OFFSET, 8'hff);
        op(0, MASK_OFFSET, 8'h80);
        op(0, 4'h5, ZERO_BYTE);
        flg <= 8'h08;
        op(1, MASK_OFFSET, 8'h08);
        op(0, STATUS_OFFSET, 8'h04);
        ins(1, 0);
        op(0, STATUS_OFFSET, 8'h07);
        ins(1, 1);
        op(0, STATUS_OFFSET, 8'h04);
        ins(1, 0);
        op(1, MASK_OFFSET, 8'hf7);
        op(0, STATUS_OFFSET, 8'h01);
        f = 8'($urandom);
        op(1, MASK_OFFSET, f);
        op(0, MASK_OFFSET, f);
        // Reset in mid-run with global enable on and every flag raised must clear mask and global
        ins(1, 0);
        flg <= 8'hff;
        rst <= 1;
        ins(0, 0);
        rst <= 0;
        op(0, STATUS_OFFSET, ZERO_BYTE);
        op(0, MASK_OFFSET, MASK_RESET);
        ins(0, 0);
        ins(0, 0);
        results;
    end
endmodule // test_interrupt_enable_mask
